// ---- src/cuw_pkg.sv ----
// Package of constants and types for the configuration user watchdog
package cuw_pkg;
	// ----------------------------------------
	// Widths and fixed pattern
	// ----------------------------------------
	localparam int CNT_W = 29;
	localparam int UPPER_W = 12;
	localparam int LOW_W = 17;
	localparam logic [LOW_W-1:0] LOW_PATTERN = 17'h00008;
	localparam logic [CNT_W-1:0] CNT_RESET = 29'h0000000;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 25000;
	localparam int RELOAD_MIN_NS = 250;
	localparam int RELOAD_MIN_CYC_RAW = (RELOAD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RELOAD_MIN_CYC = (RELOAD_MIN_CYC_RAW < 1) ? 1 : RELOAD_MIN_CYC_RAW;
	localparam int RLD_W = 4;
	localparam int TICK_SYNC_DEPTH = 2;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		CUW_FACTORY,
		CUW_LOADING,
		CUW_USER,
		CUW_EXPIRED
	} cuw_state_t;

	typedef struct packed {
		logic enable;
		logic [CNT_W-1:0] value;
	} cuw_app_info_t;

	typedef struct packed {
		logic wd_source;
		logic [UPPER_W-1:0] upper;
	} cuw_prev_t;
endpackage : cuw_pkg

// ---- src/cuw_sync.sv ----
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module cuw_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule : cuw_sync

// ---- src/cuw_watchdog.sv ----
// User watchdog of the remote upgrade configuration block
`timescale 1ns/1ps
module cuw_watchdog (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic USER_SUPPLIED_CLOCK,
	input wire logic INT_OSC_TICK,
	input wire logic USE_USER_CLOCK,
	input wire logic [11:0] TIMEOUT_UPPER,
	input wire logic CONTROL_LOAD,
	input wire logic APP_CONFIG,
	input wire logic LOAD_DONE,
	input wire logic WATCHDOG_RELOAD_N,
	input wire logic FLAG_CLEAR,
	output logic WATCHDOG_TIMEOUT_FLAG,
	output logic TIMEOUT_EVENT,
	output logic LOAD_FACTORY,
	output logic WATCHDOG_ENABLE,
	output logic [28:0] CURRENT_VALUE,
	output logic PREV_WD_SOURCE
);
	// ----------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------
	// Release is synchronised so every flop on rst_n leaves reset on the same edge
	logic rst_m_q;
	logic rst_m_d;
	logic rst_s_q;
	logic rst_s_d;
	logic rst_n;

	always_comb begin
		rst_m_d = 1'b1;
		rst_s_d = rst_m_q;
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
		end else begin
			rst_m_q <= rst_m_d;
			rst_s_q <= rst_s_d;
		end
	end
	assign rst_n = rst_s_q;

	logic uclk_s;
	logic osc_s;
	logic reload_n_s;
	logic app_s;
	logic done_s;

	cuw_sync #(.RESET_VAL(1'b0)) u_sync_uclk (.clk(SYS_CLK), .rst_n(rst_n), .din(USER_SUPPLIED_CLOCK), .dout(uclk_s));
	cuw_sync #(.RESET_VAL(1'b0)) u_sync_osc (.clk(SYS_CLK), .rst_n(rst_n), .din(INT_OSC_TICK), .dout(osc_s));
	cuw_sync #(.RESET_VAL(1'b1)) u_sync_rld (.clk(SYS_CLK), .rst_n(rst_n), .din(WATCHDOG_RELOAD_N), .dout(reload_n_s));
	cuw_sync #(.RESET_VAL(1'b0)) u_sync_app (.clk(SYS_CLK), .rst_n(rst_n), .din(APP_CONFIG), .dout(app_s));
	cuw_sync #(.RESET_VAL(1'b0)) u_sync_done (.clk(SYS_CLK), .rst_n(rst_n), .din(LOAD_DONE), .dout(done_s));

	// ----------------------------------------
	// Count tick from selected source
	// ----------------------------------------
	// Source sampled at 40 MHz, so a user clock above 20 MHz aliases; edges counted as seen
	logic src_q;
	logic src_d;
	logic tick;

	always_comb begin
		src_d = USE_USER_CLOCK ? uclk_s : osc_s;
		tick = src_d & ~src_q;
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			src_q <= 1'b0;
		end else begin
			src_q <= src_d;
		end
	end

	// ----------------------------------------
	// Reload qualification
	// ----------------------------------------
	// Short glitches on the reload pin are ignored until held long enough
	logic [cuw_pkg::RLD_W-1:0] rld_cnt_q;
	logic [cuw_pkg::RLD_W-1:0] rld_cnt_d;
	logic rld_ok;

	always_comb begin
		rld_cnt_d = rld_cnt_q;
		if (reload_n_s) begin
			rld_cnt_d = '0;
		end else if (rld_cnt_q != cuw_pkg::RLD_W'(cuw_pkg::RELOAD_MIN_CYC)) begin
			rld_cnt_d = rld_cnt_q + 1'b1;
		end
		rld_ok = (rld_cnt_q == cuw_pkg::RLD_W'(cuw_pkg::RELOAD_MIN_CYC));
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rld_cnt_q <= '0;
		end else begin
			rld_cnt_q <= rld_cnt_d;
		end
	end

	// ----------------------------------------
	// Control value, state and counter
	// ----------------------------------------
	cuw_pkg::cuw_state_t state_q;
	cuw_pkg::cuw_state_t state_d;
	logic [cuw_pkg::UPPER_W-1:0] upper_q;
	logic [cuw_pkg::UPPER_W-1:0] upper_d;
	logic [cuw_pkg::CNT_W-1:0] cnt_q;
	logic [cuw_pkg::CNT_W-1:0] cnt_d;
	logic [cuw_pkg::CNT_W-1:0] start_val;
	logic flag_q;
	logic flag_d;
	logic event_q;
	logic event_d;
	logic factory_q;
	logic factory_d;
	logic en_q;
	logic en_d;
	cuw_pkg::cuw_prev_t prev_q;
	cuw_pkg::cuw_prev_t prev_d;
	cuw_pkg::cuw_app_info_t info;

	always_comb begin
		start_val = {upper_q, cuw_pkg::LOW_PATTERN};
		state_d = state_q;
		upper_d = upper_q;
		cnt_d = cnt_q;
		flag_d = flag_q;
		event_d = 1'b0;
		factory_d = 1'b0;
		prev_d = prev_q;
		// Control value only written while the factory image runs
		if (state_q == cuw_pkg::CUW_FACTORY && CONTROL_LOAD) begin
			upper_d = TIMEOUT_UPPER;
		end
		case (state_q)
			cuw_pkg::CUW_FACTORY: begin
				cnt_d = start_val;
				if (app_s) begin
					state_d = cuw_pkg::CUW_LOADING;
				end
			end
			cuw_pkg::CUW_LOADING: begin
				cnt_d = start_val;
				if (!app_s) begin
					state_d = cuw_pkg::CUW_FACTORY;
				end else if (done_s) begin
					state_d = cuw_pkg::CUW_USER;
				end
			end
			cuw_pkg::CUW_USER: begin
				if (!app_s) begin
					state_d = cuw_pkg::CUW_FACTORY;
				end else if (!reload_n_s && (rld_ok || rld_cnt_d == cuw_pkg::RLD_W'(cuw_pkg::RELOAD_MIN_CYC))) begin
					cnt_d = start_val;
				end else if (tick) begin
					if (cnt_q == '0) begin
						event_d = 1'b1;
						state_d = cuw_pkg::CUW_EXPIRED;
					end else begin
						cnt_d = cnt_q - 1'b1;
					end
				end
			end
			cuw_pkg::CUW_EXPIRED: begin
				flag_d = 1'b1;
				prev_d.wd_source = 1'b1;
				prev_d.upper = upper_q;
				factory_d = 1'b1;
				state_d = cuw_pkg::CUW_FACTORY;
			end
			default: begin
				state_d = cuw_pkg::CUW_FACTORY;
			end
		endcase
		// Set wins over a clear in the same cycle
		if (FLAG_CLEAR && state_q != cuw_pkg::CUW_EXPIRED) begin
			flag_d = 1'b0;
		end
		en_d = (state_d == cuw_pkg::CUW_USER);
		info.enable = en_q;
		info.value = cnt_q;
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= cuw_pkg::CUW_FACTORY;
			upper_q <= '0;
			cnt_q <= cuw_pkg::CNT_RESET;
			flag_q <= 1'b0;
			event_q <= 1'b0;
			factory_q <= 1'b0;
			en_q <= 1'b0;
			prev_q <= '0;
		end else begin
			state_q <= state_d;
			upper_q <= upper_d;
			cnt_q <= cnt_d;
			flag_q <= flag_d;
			event_q <= event_d;
			factory_q <= factory_d;
			en_q <= en_d;
			prev_q <= prev_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign WATCHDOG_TIMEOUT_FLAG = flag_q;
	assign TIMEOUT_EVENT = event_q;
	assign LOAD_FACTORY = factory_q;
	assign WATCHDOG_ENABLE = info.enable;
	assign CURRENT_VALUE = info.value;
	assign PREV_WD_SOURCE = prev_q.wd_source;
endmodule : cuw_watchdog

// ---- testbench/cuw_watchdog_monitor.sv ----
// Port checker of the user watchdog
`timescale 1ns/1ps
module cuw_watchdog_monitor (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic FLAG_CLEAR,
	input wire logic WATCHDOG_TIMEOUT_FLAG,
	input wire logic TIMEOUT_EVENT,
	input wire logic LOAD_FACTORY,
	input wire logic WATCHDOG_ENABLE,
	input wire logic [28:0] CURRENT_VALUE,
	input wire logic PREV_WD_SOURCE
);
	// Outputs sit at zero a few edges past reset
	logic [3:0] up_q;
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) up_q <= 4'h0;
		else up_q <= {up_q[2:0], 1'b1};
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	evt_load_next_a: assert property (TIMEOUT_EVENT |=> LOAD_FACTORY) else $error("no reload");
	load_cause_a: assert property (LOAD_FACTORY |-> $past(TIMEOUT_EVENT)) else $error("stray load");
	evt_flags_a: assert property (TIMEOUT_EVENT |=> WATCHDOG_TIMEOUT_FLAG && PREV_WD_SOURCE)
		else $error("flags");
	evt_single_a: assert property (TIMEOUT_EVENT |=> !TIMEOUT_EVENT) else $error("long event");
	evt_zero_a: assert property (TIMEOUT_EVENT |-> $past(CURRENT_VALUE) == 29'h0 && !WATCHDOG_ENABLE)
		else $error("early event");
	// A stale count stands for one cycle after leaving user mode, two cycles after an expiry
	idle_value_a: assert property (up_q[3] && !WATCHDOG_ENABLE && !$past(WATCHDOG_ENABLE)
		&& !TIMEOUT_EVENT && !LOAD_FACTORY |-> CURRENT_VALUE[16:0] == 17'h00008) else $error("low bits");
	count_step_a: assert property (WATCHDOG_ENABLE && $past(WATCHDOG_ENABLE) |->
		CURRENT_VALUE == $past(CURRENT_VALUE) || CURRENT_VALUE == $past(CURRENT_VALUE) - 29'h1
		|| CURRENT_VALUE[16:0] == 17'h00008) else $error("step");
	flag_sticky_a: assert property ($fell(WATCHDOG_TIMEOUT_FLAG) |-> $past(FLAG_CLEAR)) else $error("flag");
	prev_sticky_a: assert property (!$fell(PREV_WD_SOURCE)) else $error("prev");
endmodule : cuw_watchdog_monitor
bind cuw_watchdog cuw_watchdog_monitor u_cuw_watchdog_monitor (
	.SYS_CLK(SYS_CLK),
	.RST_B(RST_B),
	.FLAG_CLEAR(FLAG_CLEAR),
	.WATCHDOG_TIMEOUT_FLAG(WATCHDOG_TIMEOUT_FLAG),
	.TIMEOUT_EVENT(TIMEOUT_EVENT),
	.LOAD_FACTORY(LOAD_FACTORY),
	.WATCHDOG_ENABLE(WATCHDOG_ENABLE),
	.CURRENT_VALUE(CURRENT_VALUE),
	.PREV_WD_SOURCE(PREV_WD_SOURCE)
);

// ---- testbench/cuw_app_model.sv ----
// Application logic: reload strobe and user clock
`timescale 1ns/1ps
module cuw_app_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] len,
	output logic reload_n,
	output logic uclk
);
	initial begin
		uclk = 1'h0;
		forever begin
			repeat (4) @(posedge clk);
			#2 uclk = ~uclk;
		end
	end
	// Strobe length is the caller's; short ones test refusal
	initial begin
		reload_n = 1'h1;
		forever begin
			@(posedge clk);
			if (go) begin
				#2 reload_n = 1'h0;
				repeat (len) @(posedge clk);
				#2 reload_n = 1'h1;
			end
		end
	end
endmodule : cuw_app_model

// ---- testbench/cuw_watchdog_tb.sv ----
// Self-checking bench of the user watchdog
`timescale 1ns/1ps
module cuw_watchdog_tb;
	logic SYS_CLK, RST_B, INT_OSC_TICK, USE_USER_CLOCK, CONTROL_LOAD, APP_CONFIG, LOAD_DONE, FLAG_CLEAR, go;
	logic USER_SUPPLIED_CLOCK, WATCHDOG_RELOAD_N, WATCHDOG_TIMEOUT_FLAG, TIMEOUT_EVENT, LOAD_FACTORY;
	logic WATCHDOG_ENABLE, PREV_WD_SOURCE;
	logic [11:0] TIMEOUT_UPPER;
	logic [7:0] len;
	logic [28:0] CURRENT_VALUE, v;
	logic [28:0] st = {12'h003, 17'h00008};
	int n_mismatch = 0;
	int compares = 0;
	cuw_watchdog u_cuw_watchdog (
		.SYS_CLK(SYS_CLK),
		.RST_B(RST_B),
		.USER_SUPPLIED_CLOCK(USER_SUPPLIED_CLOCK),
		.INT_OSC_TICK(INT_OSC_TICK),
		.USE_USER_CLOCK(USE_USER_CLOCK),
		.TIMEOUT_UPPER(TIMEOUT_UPPER),
		.CONTROL_LOAD(CONTROL_LOAD),
		.APP_CONFIG(APP_CONFIG),
		.LOAD_DONE(LOAD_DONE),
		.WATCHDOG_RELOAD_N(WATCHDOG_RELOAD_N),
		.FLAG_CLEAR(FLAG_CLEAR),
		.WATCHDOG_TIMEOUT_FLAG(WATCHDOG_TIMEOUT_FLAG),
		.TIMEOUT_EVENT(TIMEOUT_EVENT),
		.LOAD_FACTORY(LOAD_FACTORY),
		.WATCHDOG_ENABLE(WATCHDOG_ENABLE),
		.CURRENT_VALUE(CURRENT_VALUE),
		.PREV_WD_SOURCE(PREV_WD_SOURCE)
	);
	cuw_app_model u_cuw_app_model (.clk(SYS_CLK), .go(go), .len(len), .reload_n(WATCHDOG_RELOAD_N),
		.uclk(USER_SUPPLIED_CLOCK));
	initial begin
		SYS_CLK = 1'h0;
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end
	initial begin
		INT_OSC_TICK = 1'h0;
		forever begin
			repeat (4) @(posedge SYS_CLK);
			#2 INT_OSC_TICK = ~INT_OSC_TICK;
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
		#2;
	endtask : cyc
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'h1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	// Bounded wait; running out ends the run
	task automatic wait_hi(ref logic s);
		for (int k = 0; k < 2000 && s !== 1'h1; k++) cyc(1);
		if (s !== 1'h1) begin
			chk(1'h0, "wait bound");
			final_report();
		end
	endtask : wait_hi
	task automatic pulse(input logic [7:0] n);
		len = n;
		go = 1'h1;
		cyc(1);
		go = 1'h0;
	endtask : pulse
	task automatic t_factory;
		TIMEOUT_UPPER = 12'h003;
		CONTROL_LOAD = 1'h1;
		cyc(1);
		CONTROL_LOAD = 1'h0;
		cyc(2);
		chk(CURRENT_VALUE === st, "start");
		APP_CONFIG = 1'h1;
		cyc(8);
		TIMEOUT_UPPER = 12'h005;
		CONTROL_LOAD = 1'h1;
		cyc(1);
		CONTROL_LOAD = 1'h0;
		cyc(40);
		chk(WATCHDOG_ENABLE === 1'h0 && CURRENT_VALUE === st, "loading");
		$display("factory done");
	endtask : t_factory
	task automatic t_user;
		LOAD_DONE = 1'h1;
		wait_hi(WATCHDOG_ENABLE);
		v = CURRENT_VALUE;
		cyc(40);
		chk(CURRENT_VALUE < v && CURRENT_VALUE > v - 29'h0a, "count");
		v = CURRENT_VALUE;
		pulse(8'h05);
		cyc(20);
		chk(CURRENT_VALUE < v, "short");
		pulse(8'h10);
		cyc(14);
		chk(CURRENT_VALUE === st, "hold");
		cyc(40);
		chk(CURRENT_VALUE < st, "resume");
		$display("user done");
	endtask : t_user
	task automatic t_expire;
		APP_CONFIG = 1'h0;
		LOAD_DONE = 1'h0;
		USE_USER_CLOCK = 1'h1;
		TIMEOUT_UPPER = 12'h000;
		cyc(8);
		CONTROL_LOAD = 1'h1;
		cyc(1);
		CONTROL_LOAD = 1'h0;
		APP_CONFIG = 1'h1;
		LOAD_DONE = 1'h1;
		wait_hi(TIMEOUT_EVENT);
		cyc(1);
		chk(LOAD_FACTORY === 1'h1 && WATCHDOG_TIMEOUT_FLAG === 1'h1 && PREV_WD_SOURCE === 1'h1, "expiry");
		APP_CONFIG = 1'h0;
		LOAD_DONE = 1'h0;
		FLAG_CLEAR = 1'h1;
		cyc(1);
		FLAG_CLEAR = 1'h0;
		cyc(1);
		chk(WATCHDOG_TIMEOUT_FLAG === 1'h0 && PREV_WD_SOURCE === 1'h1, "clear");
		$display("expire done");
	endtask : t_expire
	initial begin
		{RST_B, USE_USER_CLOCK, CONTROL_LOAD, APP_CONFIG, LOAD_DONE, FLAG_CLEAR, go} = 7'h00;
		TIMEOUT_UPPER = 12'h000;
		len = 8'h00;
		cyc(10);
		RST_B = 1'h1;
		cyc(6);
		t_factory();
		t_user();
		t_expire();
		final_report();
	end
endmodule : cuw_watchdog_tb
